// >>> hw/tsr_pkg.sv
/*
  Package of the timer sync-start and simultaneous-rewrite controller:
  channel count, register offsets, reset values and method codes.
  Assumes a 32-bit APB with 12-bit byte addresses.
*/
package tsr_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NCH = 16;
  localparam int DW = 16;
  localparam int AW = 12;
  localparam int IW = 4;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFF_START = 12'h000;
  localparam logic [AW-1:0] OFF_STOP = 12'h004;
  localparam logic [AW-1:0] OFF_ENABLED = 12'h008;
  localparam logic [AW-1:0] OFF_RW_ENABLE = 12'h00C;
  localparam logic [AW-1:0] OFF_RW_SOURCE = 12'h010;
  localparam logic [AW-1:0] OFF_RW_MODE = 12'h014;
  localparam logic [AW-1:0] OFF_RW_TRIG_CHAN = 12'h018;
  localparam logic [AW-1:0] OFF_OUT_LOGIC = 12'h01C;
  localparam logic [AW-1:0] OFF_RELOAD_TRIG = 12'h020;
  localparam logic [AW-1:0] OFF_RELOAD_PEND = 12'h024;
  localparam logic [AW-1:0] OFF_OUT_LOGIC_BUF = 12'h028;
  localparam logic [AW-1:0] OFF_EXT_START_SEL = 12'h02C;
  localparam logic [AW-1:0] OFF_MASTER_SEL = 12'h030;
  // data registers and their buffers: one word per channel
  localparam logic [5:0] PAGE_REGS = 6'h00;
  localparam logic [5:0] PAGE_DATA = 6'h01;
  localparam logic [5:0] PAGE_BUF = 6'h02;
  localparam int PAGE_LSB = 6;
  localparam int IDX_LSB = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [NCH-1:0] RST_BITS = 16'h0000;
  localparam logic [DW-1:0] RST_DATA = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // rewrite method codes {enable, source, mode}
  localparam logic [2:0] METHOD_A = 3'h4;
  localparam logic [2:0] METHOD_B = 3'h5;
  localparam logic [2:0] METHOD_C1 = 3'h6;

endpackage

// >>> hw/tsr_data_mem.sv
/*
  Data registers of all channels: one write port, one registered read
  port for the bus, and every word in parallel for the buffer copy.
  Assumes writes come from the bus slave on the same clock.
*/
module tsr_data_mem
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [tsr_pkg::IW-1:0] wr_idx,
  input wire logic [tsr_pkg::DW-1:0] wr_data,
  input wire logic [tsr_pkg::IW-1:0] rd_idx,
  output logic [tsr_pkg::DW-1:0] rd_data,
  output logic [tsr_pkg::NCH-1:0][tsr_pkg::DW-1:0] all_data
);
  import tsr_pkg::*;

  typedef struct packed {
    logic [NCH-1:0][DW-1:0] mem;
    logic [DW-1:0] rd;
  } tsr_mem_type;

  tsr_mem_type state;
  tsr_mem_type next_state;

  // write port and registered read port
  always_comb
  begin
    next_state = state;
    if (wr_en)
    begin
      next_state.mem[wr_idx] = wr_data;
    end
    next_state.rd = state.mem[rd_idx];
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rd_data = state.rd;
  assign all_data = state.mem;

endmodule

// >>> hw/tsr_ctrl.sv
/*
  Start/stop and simultaneous-rewrite controller of a 16-channel timer
  array, with an APB register slave.
  Assumes the counter core reports channel start, down-at-peak and
  channel interrupt events as one-cycle pulses on pclk; the external
  sync start trigger arrives asynchronously.
*/
// Implementation choices: the address map and register access over APB.
// Function
// - a start bit written one sets the channel enabled status
// - start only arms; real start depends on mode or trigger
// - enabled channels across arrays start on the shared trigger; the code starts only those whose ext_sel bit is set
// - data and logic stay writable but act only after a copy
// - code 000 is no rewrite, 100 is method A: master start
// - code 101 is method B: master turns down at its peak
// - code 110 is method C1: interrupt of selected upper channel
// - output logic bit copies with the same trigger as data
// - which function allows which method is software's choice
// - at a channel start data and logic are copied to buffers
// - reload strobe sets the pending flag; strobe reads zero
// - a trigger with no pending flag does nothing
// - a trigger with pending flag copies data into buffers
// - after the rewrite the pending flag clears
// - a trigger-channel bit governs lower channels to the next
// - with no trigger-channel bit set, C1 never rewrites
// - C1 trigger is the upper channel interrupt at zero count
// - new output logic takes effect with the new counter value
module tsr_ctrl
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tsr_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_start_trigger_in,
  input wire logic [tsr_pkg::NCH-1:0] chan_count_start,
  input wire logic [tsr_pkg::NCH-1:0] chan_peak_down,
  input wire logic [tsr_pkg::NCH-1:0] chan_interrupt,
  output logic [tsr_pkg::NCH-1:0] chan_count_enabled,
  output logic [tsr_pkg::NCH-1:0] chan_start_pulse,
  output logic [tsr_pkg::NCH-1:0] chan_load_pulse,
  output logic [tsr_pkg::NCH-1:0][tsr_pkg::DW-1:0] chan_buf_data,
  output logic [tsr_pkg::NCH-1:0] chan_buf_logic
);
  import tsr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic waiting;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic [NCH-1:0] enabled;
    logic [NCH-1:0] ext_sel;
    logic [NCH-1:0] master;
    logic [NCH-1:0] rw_enable;
    logic [NCH-1:0] rw_source;
    logic [NCH-1:0] rw_mode;
    logic [NCH-1:0] rw_trig_chan;
    logic [NCH-1:0] out_logic;
    logic [NCH-1:0] pending;
    logic [NCH-1:0] start_p;
    logic [NCH-1:0] load_p;
    logic [NCH-1:0] buf_logic;
    logic [NCH-1:0][DW-1:0] buf_data;
    logic sync_ff1;
    logic sync_ff2;
    logic sync_ff3;
  } tsr_state_type;

  tsr_state_type state;
  tsr_state_type next_state;

  logic xfer;
  logic [5:0] page;
  logic [IW-1:0] idx;
  logic mem_wr;
  logic [DW-1:0] mem_rd;
  logic [NCH-1:0][DW-1:0] mem_all;
  logic [NCH-1:0] do_rw;
  logic [NCH-1:0] wr_mask;
  logic sync_edge;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign xfer = psel && penable && state.ready;
  assign page = paddr[AW-1:PAGE_LSB];
  assign idx = paddr[PAGE_LSB-1:IDX_LSB];
  assign mem_wr = xfer && pwrite && (page == PAGE_DATA);
  // external trigger edge, read only from the second and third stage
  assign sync_edge = state.sync_ff2 && !state.sync_ff3;
  // rewrite setup bits (enable, source, mode, trigger channel) of a running channel are held
  assign wr_mask = ~state.enabled;

  tsr_data_mem u_mem
  (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(mem_wr),
    .wr_idx(idx),
    .wr_data(pwdata[DW-1:0]),
    .rd_idx(idx),
    .rd_data(mem_rd),
    .all_data(mem_all)
  );

  // ----------------------------------------------------------------
  // rewrite trigger per channel
  // ----------------------------------------------------------------
  genvar m;
  generate
    for (m = 0; m < NCH; m++)
    begin : g_chan
      logic [IW-1:0] gm;
      logic fm;
      logic [IW-1:0] gc;
      logic fc;
      logic trig;
      // governing master: nearest master at or above this channel
      always_comb
      begin
        gm = '0;
        fm = 1'b0;
        for (int j = 0; j <= m; j++)
        begin
          if (state.master[j])
          begin
            gm = IW'(j);
            fm = 1'b1;
          end
        end
      end
      // governing upper trigger channel, up to the next one set
      always_comb
      begin
        gc = '0;
        fc = 1'b0;
        for (int j = 0; j < m; j++)
        begin
          if (state.rw_trig_chan[j])
          begin
            gc = IW'(j);
            fc = 1'b1;
          end
        end
      end
      // method decode; function fitness is left to software
      always_comb
      begin
        case ({state.rw_enable[m], state.rw_source[m], state.rw_mode[m]})
          METHOD_A: trig = fm && chan_count_start[gm];
          METHOD_B: trig = fm && chan_peak_down[gm];
          METHOD_C1: trig = fc && chan_interrupt[gc];
          default: trig = 1'b0;
        endcase
      end
      // a trigger acts only with the pending flag set
      assign do_rw[m] = trig && state.pending[m];
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [NCH-1:0] wbits;
    logic [NCH-1:0] start_bits;
    logic [NCH-1:0] stop_bits;
    logic [NCH-1:0] rld_bits;
    logic [NCH-1:0] copy;
    logic [31:0] rv;
    logic hit;
    wbits = pwdata[NCH-1:0];
    start_bits = '0;
    stop_bits = '0;
    rld_bits = '0;
    copy = '0;
    rv = RST_WORD;
    hit = 1'b1;
    next_state = state;
    next_state.sync_ff1 = sync_start_trigger_in;
    next_state.sync_ff2 = state.sync_ff1;
    next_state.sync_ff3 = state.sync_ff2;
    // read value and address check
    case (page)
      PAGE_REGS:
      begin
        case (paddr)
          OFF_START, OFF_STOP, OFF_RELOAD_TRIG: rv = RST_WORD;
          OFF_ENABLED: rv[NCH-1:0] = state.enabled;
          OFF_RW_ENABLE: rv[NCH-1:0] = state.rw_enable;
          OFF_RW_SOURCE: rv[NCH-1:0] = state.rw_source;
          OFF_RW_MODE: rv[NCH-1:0] = state.rw_mode;
          OFF_RW_TRIG_CHAN: rv[NCH-1:0] = state.rw_trig_chan;
          OFF_OUT_LOGIC: rv[NCH-1:0] = state.out_logic;
          OFF_RELOAD_PEND: rv[NCH-1:0] = state.pending;
          OFF_OUT_LOGIC_BUF: rv[NCH-1:0] = state.buf_logic;
          OFF_EXT_START_SEL: rv[NCH-1:0] = state.ext_sel;
          OFF_MASTER_SEL: rv[NCH-1:0] = state.master;
          default: hit = 1'b0;
        endcase
      end
      PAGE_DATA: rv[DW-1:0] = mem_rd;
      PAGE_BUF: rv[DW-1:0] = state.buf_data[idx];
      default: hit = 1'b0;
    endcase
    // apb: one wait cycle, answer in the second access cycle
    next_state.waiting = psel && !penable;
    next_state.ready = state.waiting && psel && penable;
    if (state.waiting)
    begin
      next_state.rdata = pwrite ? RST_WORD : rv;
      next_state.slverr = !hit;
    end
    if (xfer)
    begin
      next_state.rdata = RST_WORD;
      next_state.slverr = 1'b0;
    end
    // register writes at the completing edge
    if (xfer && pwrite && hit)
    begin
      case (paddr)
        OFF_START: start_bits = wbits;
        OFF_STOP: stop_bits = wbits;
        OFF_RELOAD_TRIG: rld_bits = wbits;
        OFF_RW_ENABLE: next_state.rw_enable =
          (state.rw_enable & ~wr_mask) | (wbits & wr_mask);
        OFF_RW_SOURCE: next_state.rw_source =
          (state.rw_source & ~wr_mask) | (wbits & wr_mask);
        OFF_RW_MODE: next_state.rw_mode =
          (state.rw_mode & ~wr_mask) | (wbits & wr_mask);
        OFF_RW_TRIG_CHAN: next_state.rw_trig_chan =
          (state.rw_trig_chan & ~wr_mask) | (wbits & wr_mask);
        OFF_OUT_LOGIC: next_state.out_logic = wbits;
        OFF_EXT_START_SEL: next_state.ext_sel = wbits;
        OFF_MASTER_SEL: next_state.master = wbits;
        default: rv = RST_WORD;
      endcase
    end
    // enable status; one write covers the whole group
    next_state.enabled = (state.enabled | start_bits) & ~stop_bits;
    // actual start: at once, or on the shared trigger
    next_state.start_p = (start_bits & ~state.ext_sel & ~stop_bits) |
      (sync_edge ? (state.enabled & state.ext_sel & ~stop_bits) : RST_BITS);
    // pending flag: the strobe wins over the clear
    next_state.pending = (state.pending & ~do_rw) | rld_bits;
    // buffer copy at start or at a rewrite, all in one edge
    copy = next_state.start_p | do_rw;
    for (int k = 0; k < NCH; k++)
    begin
      if (copy[k])
      begin
        next_state.buf_data[k] = mem_all[k];
        next_state.buf_logic[k] = state.out_logic[k];
      end
    end
    next_state.load_p = copy;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign prdata = state.rdata;
  assign pready = state.ready;
  assign pslverr = state.slverr;
  assign chan_count_enabled = state.enabled;
  assign chan_start_pulse = state.start_p;
  assign chan_load_pulse = state.load_p;
  assign chan_buf_data = state.buf_data;
  assign chan_buf_logic = state.buf_logic;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  strobe_reads_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && paddr == OFF_START) |-> prdata == RST_WORD)
    else $error("start strobe read not zero");
  start_sets_en_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (xfer && pwrite && paddr == OFF_START)
    |=> (chan_count_enabled & $past(pwdata[NCH-1:0])) ==
        $past(pwdata[NCH-1:0]))
    else $error("start bit did not enable channel");
  strobe_sets_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (xfer && pwrite && paddr == OFF_RELOAD_TRIG && pwdata[0])
    |=> state.pending[0])
    else $error("reload strobe did not set pending");
  rewrite_clears_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (do_rw[0] && !(xfer && pwrite && paddr == OFF_RELOAD_TRIG))
    |=> !state.pending[0] && chan_load_pulse[0])
    else $error("rewrite left pending set");
  no_pend_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!state.pending[0] && !(sync_edge && state.ext_sel[0]) &&
     !(xfer && pwrite && paddr == OFF_START && pwdata[0]))
    |=> !chan_load_pulse[0])
    else $error("rewrite without pending flag");
  buf_copy_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    do_rw[1] |=> chan_buf_data[1] == $past(mem_all[1]))
    else $error("buffer not copied on rewrite");
  c1_none_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state.rw_trig_chan == RST_BITS && state.rw_source == ~RST_BITS)
    |-> do_rw == RST_BITS)
    else $error("rewrite with no trigger channel");
  buf_isolated_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !next_state.load_p[2] |=> $stable(chan_buf_data[2]))
    else $error("buffer changed without copy");
  ext_start_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sync_edge && state.enabled[5] && state.ext_sel[5] &&
     !(xfer && pwrite && paddr == OFF_STOP))
    |=> chan_start_pulse[5] ##1 !chan_start_pulse[5] || sync_edge)
    else $error("external trigger did not start channel");

endmodule

// >>> bench/timer_sync_start_rewrite_test.sv
/*
  Self-checking bench of the timer sync-start and rewrite controller.
  Assumes tsr_pkg and tsr_ctrl are compiled first; the bench drives
  the APB side and the counter-core event pulses itself.
*/
module timer_sync_start_rewrite_test;
  timeunit 1ns;
  timeprecision 1ns;
  import tsr_pkg::*;

  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sync_in = 1'b0;
  logic [NCH-1:0] cstart = '0;
  logic [NCH-1:0] cpeak = '0;
  logic [NCH-1:0] cint = '0;
  logic [NCH-1:0] cen, spulse, lpulse, blog;
  logic [NCH-1:0][DW-1:0] bdata;
  int mismatches = 0;
  int check_count = 0;
  int lcnt = 0;
  int scnt = 0;
  int base;
  logic [15:0] last_load = '0;
  logic [15:0] last_start = '0;
  logic [15:0] md[16];
  logic [15:0] mb[16];
  logic [15:0] mlog, mblog, mpend, mmas, mtrg, s, p, i, f;
  logic [31:0] rd;
  logic er;
  logic [2:0] code;
  logic [2:0] codes[5] = '{METHOD_A, METHOD_B, METHOD_C1, METHOD_C1, 3'h0};

  tsr_ctrl tsr_ctrl_inst
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sync_start_trigger_in(sync_in),
    .chan_count_start(cstart), .chan_peak_down(cpeak),
    .chan_interrupt(cint), .chan_count_enabled(cen),
    .chan_start_pulse(spulse), .chan_load_pulse(lpulse),
    .chan_buf_data(bdata), .chan_buf_logic(blog)
  );

  // ----------------------------------------------------------------
  // clock, event monitor, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    forever #10 pclk = ~pclk;
  end

  // counts cycles with any load or start pulse and keeps the last mask
  always @(posedge pclk)
  begin
    if (|lpulse)
    begin
      lcnt <= lcnt + 1;
      last_load <= lpulse;
    end
    if (|spulse)
    begin
      scnt <= scnt + 1;
      last_start <= spulse;
    end
  end

  // cuts a hung run short
  initial
  begin
    #400000;
    mismatches++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [255:0] got,
    input logic [255:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // one APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [AW-1:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [AW-1:0] a,
    input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask

  // one-cycle pulses on the core event inputs, then let loads land
  task automatic pulse();
    @(posedge pclk);
    cstart <= s;
    cpeak <= p;
    cint <= i;
    @(posedge pclk);
    cstart <= '0;
    cpeak <= '0;
    cint <= '0;
    repeat (3) @(posedge pclk);
  endtask

  // exactly one load cycle with the given mask, or none for zero
  task automatic loads(input string what, input logic [15:0] mask);
    check({what, " count"}, lcnt - base, (mask != 16'h0000));
    if (mask != 16'h0000)
      check({what, " mask"}, last_load, mask);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    mpend = '0;
    check("enabled reset", cen, 16'h0000);
    rdchk("pending reset", OFF_RELOAD_PEND, 32'h0000_0000);
  endtask

  // writes fresh random data and output logic into registers and model
  task automatic new_data();
    logic [31:0] d;
    for (int m = 0; m < 16; m++)
    begin
      d = $urandom;
      apb(1'b1, {PAGE_DATA, 4'(m), 2'b00}, d);
      md[m] = d[15:0];
    end
    mlog = $urandom;
    apb(1'b1, OFF_OUT_LOGIC, 32'(mlog));
  endtask

  // model of the trigger partition: which channels rewrite now
  function automatic logic [15:0] fire();
    logic [15:0] r;
    int g;
    r = '0;
    for (int m = 0; m < 16; m++)
    begin
      g = -1;
      for (int j = 0; j < 16; j++)
        if (code == METHOD_C1 ? (j < m && mtrg[j]) : (j <= m && mmas[j]))
          g = j;
      if (g >= 0 && mpend[m])
        case (code)
          METHOD_A: r[m] = s[g];
          METHOD_B: r[m] = p[g];
          METHOD_C1: r[m] = i[g];
          default: r[m] = 1'b0;
        endcase
    end
    return r;
  endfunction

  function automatic logic [255:0] bufs();
    logic [255:0] r;
    for (int m = 0; m < 16; m++)
      r[m*16 +: 16] = mb[m];
    return r;
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(75909));
    // rewrite methods, the trigger partition and the reload handshake
    for (int it = 0; it < 5; it++)
    begin
      code = codes[it];
      do_reset();
      mmas = (16'($urandom) & 16'h5555) | 16'h0001;
      mtrg = (it == 3) ? 16'h0000 : 16'($urandom);
      new_data();
      apb(1'b1, OFF_MASTER_SEL, 32'(mmas));
      apb(1'b1, OFF_RW_ENABLE, {16'h0000, {16{code[2]}}});
      apb(1'b1, OFF_RW_SOURCE, {16'h0000, {16{code[1]}}});
      apb(1'b1, OFF_RW_MODE, {16'h0000, {16{code[0]}}});
      if (code[1])
        apb(1'b1, OFF_RW_TRIG_CHAN, 32'(mtrg));
      base = lcnt;
      apb(1'b1, OFF_START, 32'h0000_FFFF);
      repeat (3) @(posedge pclk);
      mb = md;
      mblog = mlog;
      check("enabled", cen, 16'hFFFF);
      loads("start load", 16'hFFFF);
      check("start bufs", bdata, bufs());
      check("start logic", blog, mblog);
      rdchk("start reads", OFF_START, 32'h0000_0000);
      rdchk("enabled reg", OFF_ENABLED, 32'h0000_FFFF);
      apb(1'b1, OFF_RW_MODE, {16'h0000, ~{16{code[0]}}});
      rdchk("mode lock", OFF_RW_MODE, {16'h0000, {16{code[0]}}});
      new_data();
      check("held bufs", bdata, bufs());
      check("held logic", blog, mblog);
      s = $urandom;
      p = $urandom;
      i = $urandom;
      base = lcnt;
      pulse();
      loads("idle trigger", 16'h0000);
      apb(1'b1, OFF_RELOAD_TRIG, 32'h0000_FFFF);
      mpend = 16'hFFFF;
      rdchk("reload reads", OFF_RELOAD_TRIG, 32'h0000_0000);
      rdchk("pending set", OFF_RELOAD_PEND, 32'h0000_FFFF);
      s = $urandom;
      p = $urandom;
      i = $urandom;
      f = fire();
      base = lcnt;
      pulse();
      for (int m = 0; m < 16; m++)
        if (f[m])
          mb[m] = md[m];
      mblog = (mblog & ~f) | (mlog & f);
      mpend = mpend & ~f;
      loads("rewrite", f);
      check("rewrite bufs", bdata, bufs());
      check("rewrite logic", blog, mblog);
      rdchk("pending clr", OFF_RELOAD_PEND, 32'(mpend));
      rdchk("logic buf", OFF_OUT_LOGIC_BUF, 32'(mblog));
      rdchk("buf reg", {PAGE_BUF, 4'h5, 2'b00}, 32'(mb[5]));
      rdchk("data reg", {PAGE_DATA, 4'h5, 2'b00}, 32'(md[5]));
      apb(1'b1, OFF_STOP, 32'h0000_FFFF);
      repeat (2) @(posedge pclk);
      check("stopped", cen, 16'h0000);
      $display("test rewrite %0d done", it);
    end
    // channel 5 waits for the external sync trigger, others start
    do_reset();
    apb(1'b1, OFF_EXT_START_SEL, 32'h0000_0020);
    base = scnt;
    apb(1'b1, OFF_START, 32'h0000_FFFF);
    repeat (3) @(posedge pclk);
    check("armed", cen, 16'hFFFF);
    check("direct start", last_start, 16'hFFDF);
    sync_in <= 1'b1;
    repeat (6) @(posedge pclk);
    check("sync start", last_start, 16'h0020);
    check("start count", scnt - base, 2);
    sync_in <= 1'b0;
    apb(1'b0, 12'h0C0, 32'h0000_0000);
    check("unmapped err", er, 1'b1);
    check("unmapped data", rd, 32'h0000_0000);
    $display("test sync start done");
    complete_run();
  end
endmodule
